/* File: design/isa_io_recovery_alias.sv */
// What this block does
// R1 - With aliasing on, 90h-9Fh accesses map onto 80h-8Fh.
// R2 - With aliasing on, only writes in that window reach ISA; reads stay.
// R3 - Alias control bit set: whole 90h-9Fh window forwarded, both ways.
// R4 - Port 92h is never aliased and is forwarded to ISA on all but ISA master accesses.
// R5 - Alias control bit set: ISA master accesses to 90h-9Fh get no response.
// R6 - Alias control bit set: 90h-9Fh accesses do not reload fast-off timer.
// R7 - Bit 6 selects programmed 8-bit recovery; clear means base 3.5 clocks.
// R8 - 8-bit field codes 001-111 add 1-7 clocks, 000 adds 8.
// R9 - Bit 2 enables 16-bit field; clear means base 3.5 clocks only.
// R10 - 16-bit field codes 01-11 add 1-3 clocks, 00 adds 4.
// R11 - At least 3.5 ISA clocks from command release to next command.
// R12 - Sub-cycles of one access run back to back with no recovery.
// R13 - Programmed recovery extends the gap in whole ISA clocks.
// R14 - Recovery restarts at each command end and holds the next command.
// R15 - Register is read/write; new value applies from next ISA cycle.
`timescale 1ns/10ps
`include "isa_io_recovery_alias_defines.svh"

module isa_io_recovery_alias
	import isa_io_recovery_alias_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        ISA_CLK,
	input  wire logic        CFG_WR,
	input  wire logic        CFG_RD,
	input  wire logic [7:0]  CFG_ADDR,
	input  wire logic [7:0]  CFG_WDATA,
	output logic      [7:0]  CFG_RDATA,
	input  wire logic        REQ_VALID,
	input  wire logic        REQ_WRITE,
	input  wire logic        REQ_IS16,
	input  wire logic        REQ_SUBCYCLE,
	input  wire logic        REQ_ISA_MASTER,
	input  wire logic [15:0] REQ_ADDR,
	output logic             REQ_DONE,
	output logic             REQ_CLAIM,
	output logic             REQ_FWD,
	output logic             FAST_OFF_RELOAD,
	output logic             ISA_IOR_N,
	output logic             ISA_IOW_N,
	output logic      [15:0] ISA_SA
);

	logic [7:0]  cfg_q;
	logic [2:0]  sync_q;
	logic        isa_edge;
	cyc_state_t  state_q;
	logic [4:0]  rec_q;
	logic [2:0]  width_q;
	logic        is16_q;
	logic        sub_q;
	logic        in_win;
	logic        fwd_d;
	logic        claim_d;
	logic [15:0] addr_d;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic alias_win(input logic [15:0] a);
		alias_win = (a[15:4] == `ALIAS_WIN_TOP);
	endfunction
	// Gap in ISA clock half periods: base 3.5 clocks plus whole clocks.
	function automatic logic [4:0] rec_half(input logic [7:0] c,
		input logic w16);
		logic [3:0] extra;
		extra = 4'h0;
		if (!w16 && c[`REC_EN8_BIT])
			extra = (c[`REC_F8_HI:`REC_F8_LO] == 3'h0) ? 4'h8 : // R8
				{1'b0, c[`REC_F8_HI:`REC_F8_LO]};
		if (w16 && c[`REC_EN16_BIT])
			extra = (c[`REC_F16_HI:`REC_F16_LO] == 2'h0) ? 4'h4 : // R10
				{2'b00, c[`REC_F16_HI:`REC_F16_LO]};
		rec_half = `BASE_REC_HALF + {extra, 1'b0}; // R7 R9 R13
	endfunction

	// ------------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			cfg_q <= `REC_RESET;
		else if (CFG_WR && CFG_ADDR == `REC_OFFSET)
			cfg_q <= CFG_WDATA; // R15
	end
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			CFG_RDATA <= 8'h00;
		else if (CFG_RD)
			CFG_RDATA <= (CFG_ADDR == `REC_OFFSET) ? cfg_q : 8'h00; // R15
	end
	// ------------------------------------------------------------------
	// ISA clock edge finder
	// ------------------------------------------------------------------
	// Both edges are used so the half clock of the base gap is exact.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			sync_q <= 3'b000;
		else
			sync_q <= {sync_q[1:0], ISA_CLK};
	end

	assign isa_edge = sync_q[2] ^ sync_q[1];
	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	always_comb
	begin
		in_win  = alias_win(REQ_ADDR);
		addr_d  = REQ_ADDR; // R3
		claim_d = 1'b1;
		fwd_d   = 1'b1;
		if (REQ_ISA_MASTER)
		begin
			fwd_d   = 1'b0;
			claim_d = in_win && !cfg_q[`REC_ALIAS_BIT]; // R5
		end
		else if (in_win && REQ_ADDR[3:0] == `DISTINCT_PORT)
			fwd_d = 1'b1; // R4
		else if (in_win && !cfg_q[`REC_ALIAS_BIT])
		begin
			addr_d = {REQ_ADDR[15:8], `ALIAS_DST_TOP, REQ_ADDR[3:0]}; // R1
			fwd_d  = REQ_WRITE; // R2
		end
		// With the alias bit set the window passes through untouched.
	end
	// ------------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_q         <= S_IDLE;
			REQ_DONE        <= 1'b0;
			REQ_CLAIM       <= 1'b0;
			REQ_FWD         <= 1'b0;
			FAST_OFF_RELOAD <= 1'b0;
			ISA_IOR_N       <= 1'b1;
			ISA_IOW_N       <= 1'b1;
			ISA_SA          <= 16'h0000;
			width_q         <= 3'h0;
			is16_q          <= 1'b0;
			sub_q           <= 1'b0;
		end
		else
		begin
			REQ_DONE        <= 1'b0;
			FAST_OFF_RELOAD <= 1'b0;
			case (state_q)
			S_IDLE:
			begin
				if (REQ_VALID && !REQ_DONE)
				begin
					REQ_CLAIM <= claim_d;
					REQ_FWD   <= fwd_d;
					ISA_SA    <= addr_d;
					is16_q    <= REQ_IS16;
					sub_q     <= REQ_SUBCYCLE;
					FAST_OFF_RELOAD <= claim_d &&
						!(in_win && cfg_q[`REC_ALIAS_BIT]); // R6
					if (fwd_d)
						state_q <= S_WAIT;
					else
						REQ_DONE <= 1'b1;
				end
			end
			S_WAIT:
			begin
				// Sub-cycles skip the gap; others wait out the counter.
				if (isa_edge && (sub_q || rec_q == 5'h00)) // R12 R14
				begin
					ISA_IOR_N <= REQ_WRITE;
					ISA_IOW_N <= !REQ_WRITE;
					width_q   <= `CMD_WIDTH_HALF;
					state_q   <= S_CMD;
				end
			end
			S_CMD:
			begin
				if (isa_edge)
				begin
					width_q <= width_q - 3'h1;
					if (width_q == 3'h1)
					begin
						ISA_IOR_N <= 1'b1;
						ISA_IOW_N <= 1'b1;
						REQ_DONE  <= 1'b1;
						state_q   <= S_IDLE;
					end
				end
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end
	// Recovery counter, reloaded as each command is released.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			rec_q <= 5'h00;
		else if (state_q == S_CMD && isa_edge && width_q == 3'h1)
			rec_q <= rec_half(cfg_q, is16_q) - 5'h01; // R11 R14 R15
		else if (isa_edge && rec_q != 5'h00)
			rec_q <= rec_q - 5'h01;
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	logic       cmd_n;
	logic [4:0] gap_q;
	logic       idle_req;
	assign cmd_n    = ISA_IOR_N & ISA_IOW_N;
	assign idle_req = state_q == S_IDLE && REQ_VALID && !REQ_DONE;
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			gap_q <= `GAP_SAT;
		else if (!cmd_n)
			gap_q <= 5'h00;
		else if (isa_edge && gap_q != `GAP_SAT)
			gap_q <= gap_q + 5'h01;
	end

	property p_alias_write;
		idle_req && !REQ_ISA_MASTER && alias_win(REQ_ADDR) &&
		REQ_ADDR[3:0] != 4'h2 && !cfg_q[7] && REQ_WRITE
		|=> REQ_FWD && ISA_SA[7:4] == 4'h8;
	endproperty
	a_alias_write: assert property (p_alias_write) // R1
		else $error("aliased write not mapped to 80h-8Fh");
	property p_alias_read;
		idle_req && !REQ_ISA_MASTER && alias_win(REQ_ADDR) &&
		REQ_ADDR[3:0] != 4'h2 && !cfg_q[7] && !REQ_WRITE
		|=> REQ_DONE && !REQ_FWD && ISA_IOR_N;
	endproperty
	a_alias_read: assert property (p_alias_read) // R2
		else $error("aliased read was forwarded");
	property p_no_alias;
		idle_req && !REQ_ISA_MASTER && alias_win(REQ_ADDR) && cfg_q[7]
		|=> REQ_FWD && ISA_SA == $past(REQ_ADDR);
	endproperty
	a_no_alias: assert property (p_no_alias) // R3
		else $error("window not forwarded unchanged");
	property p_port92;
		idle_req && !REQ_ISA_MASTER && REQ_ADDR == 16'h0092
		|=> REQ_FWD && ISA_SA == 16'h0092;
	endproperty
	a_port92: assert property (p_port92) // R4
		else $error("port 92h not forwarded as itself");
	property p_isa_ignore;
		idle_req && REQ_ISA_MASTER && alias_win(REQ_ADDR) && cfg_q[7]
		|=> REQ_DONE && !REQ_CLAIM;
	endproperty
	a_isa_ignore: assert property (p_isa_ignore) // R5
		else $error("ISA master window access was claimed");
	property p_no_reload;
		idle_req && alias_win(REQ_ADDR) && cfg_q[7] |=> !FAST_OFF_RELOAD;
	endproperty
	a_no_reload: assert property (p_no_reload) // R6
		else $error("fast-off timer reloaded for window access");
	property p_rec_load;
		$rose(cmd_n) |-> rec_q == rec_half($past(cfg_q), is16_q) - 5'h01;
	endproperty
	a_rec_load: assert property (p_rec_load) // R8
		else $error("recovery count does not match field");
	property p_min_gap;
		$fell(cmd_n) && !sub_q |-> $past(gap_q) >= 5'h06;
	endproperty
	a_min_gap: assert property (p_min_gap) // R11
		else $error("recovery gap shorter than 3.5 clocks");
	property p_sub_fast;
		state_q == S_WAIT && sub_q && isa_edge |=> !cmd_n;
	endproperty
	a_sub_fast: assert property (p_sub_fast) // R12
		else $error("sub-cycle delayed by recovery");
	property p_cover_alias;
		idle_req && alias_win(REQ_ADDR) && !cfg_q[7] && REQ_WRITE;
	endproperty
	c_cover_alias: cover property (p_cover_alias);
	property p_cover_b2b;
		$fell(cmd_n) && !sub_q && gap_q < 5'h0A;
	endproperty
	c_cover_b2b: cover property (p_cover_b2b);
	property p_cover_sub;
		$fell(cmd_n) && sub_q;
	endproperty
	c_cover_sub: cover property (p_cover_sub);
endmodule

/* File: design/isa_io_recovery_alias_defines.svh */
`ifndef ISA_IO_RECOVERY_ALIAS_DEFINES_SVH
`define ISA_IO_RECOVERY_ALIAS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REC_OFFSET       8'h4C
`define REC_RESET        8'h4D
`define REC_ALIAS_BIT    7
`define REC_EN8_BIT      6
`define REC_F8_HI        5
`define REC_F8_LO        3
`define REC_EN16_BIT     2
`define REC_F16_HI       1
`define REC_F16_LO       0

// ----------------------------------------------------------------------
// Address windows
// ----------------------------------------------------------------------
`define ALIAS_WIN_TOP    12'h009
`define ALIAS_DST_TOP    4'h8
`define DISTINCT_PORT    4'h2

// ----------------------------------------------------------------------
// Timing in half periods of the ISA bus clock
// ----------------------------------------------------------------------
`define BASE_REC_HALF    5'h07
`define CMD_WIDTH_HALF   3'h6
`define GAP_SAT          5'h1F

`endif

/* File: design/isa_io_recovery_alias_pkg.sv */
package isa_io_recovery_alias_pkg;

	typedef enum logic [1:0]
	{
		S_IDLE = 2'b00,
		S_WAIT = 2'b01,
		S_CMD  = 2'b10
	} cyc_state_t;

endpackage

/* File: dv/isa_target_model.sv */
`timescale 1ns/10ps
module isa_target_model
(
	input  wire logic        clk,
	input  wire logic        ior_n,
	input  wire logic        iow_n,
	input  wire logic [15:0] sa,
	output int               gap,
	output logic [15:0]      last_sa,
	output logic             last_wr
);
	int   idle_q = 0;
	logic busy_q = 1'b0;

	// A target only sees strobes, so the gap is timed in system clocks
	// from one command release to the next command strobe.
	always @(posedge clk)
	begin
		busy_q <= !(ior_n && iow_n);
		if (!(ior_n && iow_n) && !busy_q)
		begin
			gap     <= idle_q;
			last_sa <= sa;
			last_wr <= !iow_n;
		end
		idle_q <= (ior_n && iow_n) ? idle_q + 1 : 0;
	end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
	typedef struct packed
	{
		logic [7:0]  cfg;
		logic        wr;
		logic        isam;
		logic [15:0] addr;
		logic        claim;
		logic        fwd;
		logic [15:0] sa;
		logic        rel;
	} arow_t;
	typedef struct packed
	{
		logic [7:0] cfg;
		logic       is16;
		logic       sub;
		logic [4:0] h;
	} grow_t;

	logic        clk, rst, isa_clk, cfg_wr, cfg_rd, req_valid, req_write;
	logic        req_is16, req_sub, req_isam, rel;
	logic [7:0]  cfg_addr, cfg_wdata, rdata;
	logic [15:0] req_addr, sa, last_sa;
	logic        done, claim, fwd, reload, ior_n, iow_n, last_wr;
	int          failures = 0;
	int          tests_run = 0;
	int          gap, exp;

	// Alias decode cases: cfg, write, isa master, addr, then expected
	// claim, forward, isa address, fast-off reload.
	arow_t arows [8] = '{
		'{8'h4D, 1'b1, 1'b0, 16'h0095, 1'b1, 1'b1, 16'h0085, 1'b1},
		'{8'h4D, 1'b0, 1'b0, 16'h0095, 1'b1, 1'b0, 16'h0085, 1'b1},
		'{8'h4D, 1'b0, 1'b0, 16'h0092, 1'b1, 1'b1, 16'h0092, 1'b1},
		'{8'hCD, 1'b0, 1'b0, 16'h0095, 1'b1, 1'b1, 16'h0095, 1'b0},
		'{8'hCD, 1'b1, 1'b1, 16'h0095, 1'b0, 1'b0, 16'h0000, 1'b0},
		'{8'h4D, 1'b1, 1'b1, 16'h0095, 1'b1, 1'b0, 16'h0000, 1'b1},
		'{8'hCD, 1'b1, 1'b0, 16'h009F, 1'b1, 1'b1, 16'h009F, 1'b0},
		'{8'h4D, 1'b1, 1'b0, 16'h0300, 1'b1, 1'b1, 16'h0300, 1'b1}
	};
	// Recovery cases: cfg, 16-bit, sub-cycle, gap in isa half periods.
	grow_t grows [8] = '{
		'{8'h4D, 1'b0, 1'b0, 5'h09},
		'{8'h0D, 1'b0, 1'b0, 5'h07},
		'{8'h78, 1'b0, 1'b0, 5'h15},
		'{8'h40, 1'b0, 1'b0, 5'h17},
		'{8'h04, 1'b1, 1'b0, 5'h0F},
		'{8'h07, 1'b1, 1'b0, 5'h0D},
		'{8'h03, 1'b1, 1'b0, 5'h07},
		'{8'h4D, 1'b0, 1'b1, 5'h00}
	};

	isa_io_recovery_alias u_isa_io_recovery_alias
	(
		.CLK(clk), .RESET(rst), .ISA_CLK(isa_clk), .CFG_WR(cfg_wr),
		.CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
		.CFG_RDATA(rdata), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
		.REQ_IS16(req_is16), .REQ_SUBCYCLE(req_sub),
		.REQ_ISA_MASTER(req_isam), .REQ_ADDR(req_addr), .REQ_DONE(done),
		.REQ_CLAIM(claim), .REQ_FWD(fwd), .FAST_OFF_RELOAD(reload),
		.ISA_IOR_N(ior_n), .ISA_IOW_N(iow_n), .ISA_SA(sa)
	);
	isa_target_model u_isa_target_model
	(
		.clk(clk), .ior_n(ior_n), .iow_n(iow_n), .sa(sa), .gap(gap),
		.last_sa(last_sa), .last_wr(last_wr)
	);

	// ------------------------------------------------------------------
	// Clocks and shared tasks
	// ------------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// The isa clock is offset so its edges drift against the system clock.
	initial
	begin
		isa_clk = 1'b0;
		#3;
		forever #62.5 isa_clk = ~isa_clk;
	end

	task automatic conclude;
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		cfg_wr = w;
		cfg_rd = !w;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
	endtask

	task automatic io(input logic w, s16, sub, im, input logic [15:0] a);
		int n;
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_is16 = s16;
		req_sub = sub;
		req_isam = im;
		req_addr = a;
		rel = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			rel = rel | reload;
			n++;
		end
		chk(n < 2000, "request never completed");
		req_valid = 1'b0;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		{rst, cfg_wr, cfg_rd, req_valid, req_write, req_is16} = 6'h20;
		{req_sub, req_isam, cfg_addr, cfg_wdata, req_addr} = '0;
		repeat (6) @(negedge clk);
		chk(ior_n === 1'b1 && iow_n === 1'b1 && done === 1'b0, "reset idle");
		rst = 1'b0;
		cfg(1'b0, 8'h4C, 8'h00);
		chk(rdata === 8'h4D, "register reset value");
		cfg(1'b1, 8'h4E, 8'hFF);
		cfg(1'b0, 8'h4E, 8'h00);
		chk(rdata === 8'h00, "unmapped read not zero");
		foreach (arows[i])
		begin
			cfg(1'b1, 8'h4C, arows[i].cfg);
			io(arows[i].wr, 1'b0, 1'b0, arows[i].isam, arows[i].addr);
			chk(claim === arows[i].claim, "claim wrong");
			chk(fwd === arows[i].fwd, "forward wrong");
			chk(rel === arows[i].rel, "reload wrong");
			chk(arows[i].isam || sa === arows[i].sa, "alias addr");
			if (arows[i].fwd)
				chk(last_sa === arows[i].sa && last_wr === arows[i].wr,
					"isa cycle wrong");
		end
		foreach (grows[i])
		begin
			cfg(1'b1, 8'h4C, grows[i].cfg);
			cfg(1'b0, 8'h4C, 8'h00);
			chk(rdata === grows[i].cfg, "register readback");
			io(1'b1, grows[i].is16, 1'b0, 1'b0, 16'h0300);
			io(1'b1, grows[i].is16, grows[i].sub, 1'b0, 16'h0301);
			exp = grows[i].h * 25 / 4;
			chk(gap >= exp - 4 && gap <= exp + 10, "recovery gap");
		end
		cfg(1'b1, 8'h4C, 8'h00);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		cfg(1'b0, 8'h4C, 8'h00);
		chk(rdata === 8'h4D, "second reset value");
		conclude;
	end

	initial
	begin
		#600000;
		failures++;
		conclude;
	end
endmodule
